// File: src/sfp_pkg.sv
// Purpose: Shared constants for the serial flash protect and framing block
// Assumes: 64 KB blocks, 512 blocks, 4 KB sectors, 4 Kbit secure area
// Notes: Command codes here are local encodings, not any vendor's opcodes
package sfp_pkg;
    localparam int BLK_W = 9;
    localparam int NUM_BLKS = 512;
    localparam int TOP_BLK = 511;
    localparam int SEC_W = 4;
    localparam int LVL_ALL = 10;
    localparam int LVL_MAX_RANGE = 9;
    localparam int SECURE_BYTES = 512;
    localparam int SERIAL_END = 16;
    localparam int SECREG_FLOCK_BIT = 0;
    localparam int SECREG_CLOCK_BIT = 1;
    localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'h01;
    localparam logic [7:0] CMD_WRDI = 8'h02;
    localparam logic [7:0] CMD_WRITE_STATUS_CMD = 8'h03;
    localparam logic [7:0] CMD_PP = 8'h04;
    localparam logic [7:0] CMD_SE = 8'h05;
    localparam logic [7:0] CMD_BE = 8'h06;
    localparam logic [7:0] CMD_ENTER_SECURE_AREA_CMD = 8'h07;
    localparam logic [7:0] CMD_EXIT_SECURE_AREA_CMD = 8'h08;
    localparam logic [7:0] CMD_WRITE_SECURITY_REG_CMD = 8'h09;
    localparam logic [7:0] CMD_SBLK = 8'h0a;
    localparam logic [7:0] CMD_SBULK = 8'h0b;
    localparam logic [7:0] CMD_READ = 8'h10;
    localparam logic [7:0] CMD_RDSR = 8'h11;
    localparam logic [7:0] CMD_RDSCUR = 8'h12;
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_PROG = 3'h1;
    localparam logic [2:0] OP_SERASE = 3'h2;
    localparam logic [2:0] OP_BERASE = 3'h3;
    localparam logic [2:0] OP_WRITE_STATUS_CMD = 3'h4;
    localparam logic [2:0] OP_LOCK = 3'h5;
    localparam logic [2:0] OP_UNLOCK = 3'h6;
    localparam logic [2:0] OP_SECLOCK = 3'h7;
endpackage : sfp_pkg

// File: src/sfp_protect.sv
// Purpose: Command framing and write protection for a serial NOR flash front end
// Assumes: Link logic on sclk_i; core logic on mclk_i; frame end crosses as a synced select edge
// Notes: Notes on behaviour below
// Notes on behaviour
// - Bottom select 0: levels 1-9 protect top blocks
// - Level 0 none; levels 10-15 protect all
// - Bottom select 1: levels 1-9 protect from block 0
// - Protected blocks read-only to program and erase
// - Secure area 4 Kbit, serial then customer
// - Security bit 0 reports factory lock
// - Security write command sets customer lock bit 1
// - Either lock stays set until srst_i
// - Secure mode denies main array access
// - Block locks 64 KB; top block per 4 KB
// - Invalid command: standby, output off until select rises
// - Valid command stays active until select rises
// - Sample on rising clock, launch on falling
// - Reads may end after any bit
// - Write-type commands need byte-aligned select rise
// - Array access ignored while busy
// - Changes other than secure mode entry and exit need write enable latch set
`timescale 1ns/1ns
module sfp_protect #(
    parameter int ADDR_W = 25,
    parameter int BUSY_CYC = 8
) (
    input wire logic mclk_i,                // Core clock
    input wire logic srst_i,                // Synchronous reset, high
    input wire logic sclk_i,                // Serial clock from host
    input wire logic cs_n_i,                // Chip select, low active
    input wire logic si_i,                  // Serial data in
    output logic so_o,                      // Serial data out
    output logic so_oe_o,                   // Serial out drive enable
    input wire logic factory_lock_i,        // Factory lock strap
    input wire logic op_done_i,             // Array operation finished
    output logic op_start_o,                // Array operation start pulse
    output logic [2:0] op_kind_o,           // Array operation kind
    output logic [ADDR_W-1:0] op_addr_o,    // Array operation address
    output logic op_secure_o,               // Operation targets secure area
    output logic [3:0] protect_level_o,     // Level bits 3..0
    output logic bottom_select_o,           // Top/bottom select
    output logic write_enable_latch_o,      // Write enable latch
    output logic busy_o,                    // Operation in progress
    output logic secure_mode_o,             // Secure area mode
    output logic [1:0] security_reg_o,      // Customer and factory lock
    output logic reject_o                   // Command rejected pulse
);
    // Link domain: shift register, bit counter, framing state
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [5:0] byte_q, byte_d;
    logic [7:0] cmd_q, cmd_d;
    logic [31:0] arg_q, arg_d;
    logic invalid_q, invalid_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] rd_q;
    logic so_q;

    function automatic logic valid_cmd(input logic [7:0] c);
        valid_cmd = (c >= sfp_pkg::CMD_WRITE_ENABLE_CMD && c <= sfp_pkg::CMD_SBULK) ||
            (c >= sfp_pkg::CMD_READ && c <= sfp_pkg::CMD_RDSCUR);
    endfunction : valid_cmd

    function automatic logic is_read(input logic [7:0] c);
        is_read = c >= sfp_pkg::CMD_READ;
    endfunction : is_read

    always_comb begin
        sh_d = {sh_q[6:0], si_i};
        bit_d = bit_q + 3'h1;
        byte_d = byte_q;
        cmd_d = cmd_q;
        arg_d = arg_q;
        invalid_d = invalid_q;
        if (bit_q == 3'h7) begin
            if (byte_q != 6'h3f) begin
                byte_d = byte_q + 6'h01;
            end
            if (byte_q == 6'h00) begin
                cmd_d = sh_d;
                invalid_d = !valid_cmd(sh_d);
            end else if (byte_q < 6'h05) begin
                arg_d = {arg_q[23:0], sh_d};
            end
        end
    end

    // Frame state restarts on the chip select edge, not on a free clock
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            byte_q <= 6'h00;
            cmd_q <= 8'h00;
            arg_q <= 32'h0;
            invalid_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            cmd_q <= cmd_d;
            arg_q <= arg_d;
            invalid_q <= invalid_d;
        end
    end

    // Read data: status byte or security byte, looped
    always_comb begin
        tx_d = tx_q;
        if (bit_q == 3'h0) begin
            tx_d = (cmd_q == sfp_pkg::CMD_RDSCUR) ? {6'h00, rd_q[7:6]} :
                {2'b00, rd_q[5:0]};
        end
    end

    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            tx_q <= 8'h00;
            so_q <= 1'b0;
        end else begin
            tx_q <= (bit_q == 3'h0) ? {tx_d[6:0], 1'b0} : {tx_q[6:0], 1'b0};
            so_q <= (bit_q == 3'h0) ? tx_d[7] : tx_q[7];
        end
    end

    assign so_o = so_q;
    // Driven only after a valid read command byte; released with select
    assign so_oe_o = !cs_n_i && !invalid_q && byte_q != 6'h00 && is_read(cmd_q);

    // Frame end: capture command and alignment at the rising select edge
    logic [7:0] fin_cmd_q;
    logic [31:0] fin_arg_q;
    logic fin_align_q, fin_ok_q;
    always_ff @(posedge cs_n_i) begin
        fin_cmd_q <= cmd_q;
        fin_arg_q <= arg_q;
        fin_align_q <= (bit_q == 3'h0) && byte_q != 6'h00;
        fin_ok_q <= !invalid_q;
    end

    // Core domain: the synchronised select rise marks a finished frame; the captured
    // frame words are already stable then and hold until the next frame ends
    logic [2:0] cs_sync_q, cs_sync_d;
    always_comb begin
        cs_sync_d = {cs_sync_q[1:0], cs_n_i};
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cs_sync_q <= 3'h7; // Idle level, so no false frame end after reset
        end else begin
            cs_sync_q <= cs_sync_d;
        end
    end
    wire fin_ev = cs_sync_q[1] && !cs_sync_q[2];

    logic [3:0] lvl_q, lvl_d;
    logic tb_q, tb_d, wel_q, wel_d, busy_q, busy_d, sec_q, sec_d;
    localparam int NUM_LOCKS = sfp_pkg::NUM_BLKS + (1 << sfp_pkg::SEC_W);
    logic flock_q, flock_d, clock_q, clock_d;
    logic [NUM_LOCKS-1:0] lock_q, lock_d;
    logic start_q, start_d, rej_q, rej_d, osec_q, osec_d;
    logic [2:0] kind_q, kind_d;
    logic [ADDR_W-1:0] addr_q, addr_d;

    // Range decode for a block under the current level and select
    function automatic logic blk_prot(input logic [8:0] b, input logic [3:0] l,
                                      input logic t);
        logic [9:0] n;
        n = 10'h001 << (l - 4'h1);
        if (l == 4'h0) begin
            blk_prot = 1'b0;
        end else if (l >= 4'(sfp_pkg::LVL_ALL)) begin
            blk_prot = 1'b1;
        end else if (t) begin
            blk_prot = {1'b0, b} < n;
        end else begin
            blk_prot = {1'b0, b} >= 10'(sfp_pkg::NUM_BLKS) - n;
        end
    endfunction : blk_prot

    // Individual lock bit index: top block uses its 16 sector bits
    function automatic int lock_idx(input logic [ADDR_W-1:0] a);
        if (a[ADDR_W-1 -: sfp_pkg::BLK_W] == 9'(sfp_pkg::TOP_BLK)) begin
            lock_idx = sfp_pkg::NUM_BLKS + int'(a[15:12]);
        end else begin
            lock_idx = int'(a[ADDR_W-1 -: sfp_pkg::BLK_W]);
        end
    endfunction : lock_idx

    wire [ADDR_W-1:0] fa = fin_arg_q[ADDR_W-1:0];
    wire [8:0] fblk = fa[ADDR_W-1 -: sfp_pkg::BLK_W];
    wire write_cmd = !is_read(fin_cmd_q);
    wire prot_hit = blk_prot(fblk, lvl_q, tb_q) || lock_q[lock_idx(fa)];
    wire sec_full = clock_q || flock_q;
    logic [7:0] bcnt_q, bcnt_d;

    always_comb begin
        lvl_d = lvl_q;
        tb_d = tb_q;
        wel_d = wel_q;
        sec_d = sec_q;
        flock_d = flock_q | factory_lock_i;
        clock_d = clock_q;
        lock_d = lock_q;
        start_d = 1'b0;
        rej_d = 1'b0;
        kind_d = kind_q;
        addr_d = addr_q;
        osec_d = osec_q;
        busy_d = busy_q;
        bcnt_d = (bcnt_q != 8'h00) ? bcnt_q - 8'h01 : 8'h00;
        if (busy_q && op_done_i && bcnt_q == 8'h00) begin
            busy_d = 1'b0;
            wel_d = 1'b0;
        end
        if (fin_ev) begin
            if (!fin_ok_q || (write_cmd && !fin_align_q)) begin
                rej_d = 1'b1;
            end else if (busy_q) begin
                rej_d = write_cmd;
            end else begin
                case (fin_cmd_q)
                    sfp_pkg::CMD_WRITE_ENABLE_CMD: wel_d = 1'b1;
                    sfp_pkg::CMD_WRDI: wel_d = 1'b0;
                    sfp_pkg::CMD_ENTER_SECURE_AREA_CMD: sec_d = 1'b1;
                    sfp_pkg::CMD_EXIT_SECURE_AREA_CMD: sec_d = 1'b0;
                    sfp_pkg::CMD_WRITE_STATUS_CMD: begin
                        if (wel_q) begin
                            lvl_d = fin_arg_q[5:2];
                            tb_d = fin_arg_q[6];
                            kind_d = sfp_pkg::OP_WRITE_STATUS_CMD;
                            start_d = 1'b1;
                        end
                    end
                    sfp_pkg::CMD_WRITE_SECURITY_REG_CMD: begin
                        if (wel_q) begin
                            clock_d = 1'b1;
                            kind_d = sfp_pkg::OP_SECLOCK;
                            start_d = 1'b1;
                        end
                    end
                    sfp_pkg::CMD_SBLK, sfp_pkg::CMD_SBULK: begin
                        if (wel_q && !sec_q) begin
                            lock_d[lock_idx(fa)] = (fin_cmd_q == sfp_pkg::CMD_SBLK);
                            kind_d = (fin_cmd_q == sfp_pkg::CMD_SBLK) ? sfp_pkg::OP_LOCK :
                                sfp_pkg::OP_UNLOCK;
                            start_d = 1'b1;
                        end
                    end
                    sfp_pkg::CMD_PP, sfp_pkg::CMD_SE, sfp_pkg::CMD_BE: begin
                        if (wel_q) begin
                            kind_d = (fin_cmd_q == sfp_pkg::CMD_PP) ? sfp_pkg::OP_PROG :
                                (fin_cmd_q == sfp_pkg::CMD_SE) ? sfp_pkg::OP_SERASE :
                                sfp_pkg::OP_BERASE;
                            osec_d = sec_q;
                            addr_d = sec_q ? ADDR_W'(fa[8:0]) : fa;
                            // Secure area: page program only, below lock; array: unprotected
                            start_d = sec_q ? (fin_cmd_q == sfp_pkg::CMD_PP && !sec_full &&
                                fa[8:0] >= 9'(sfp_pkg::SERIAL_END)) : !prot_hit;
                            if (!start_d) begin
                                kind_d = sfp_pkg::OP_NONE;
                                wel_d = 1'b0;
                            end
                        end
                    end
                    default: ;
                endcase
                if (start_d) begin
                    osec_d = sec_q;
                    busy_d = 1'b1;
                    bcnt_d = 8'(BUSY_CYC);
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            lvl_q <= 4'h0;
            tb_q <= 1'b0;
            wel_q <= 1'b0;
            busy_q <= 1'b0;
            sec_q <= 1'b0;
            flock_q <= 1'b0;
            clock_q <= 1'b0;
            lock_q <= '0;
            start_q <= 1'b0;
            rej_q <= 1'b0;
            kind_q <= sfp_pkg::OP_NONE;
            addr_q <= '0;
            osec_q <= 1'b0;
            bcnt_q <= 8'h00;
        end else begin
            lvl_q <= lvl_d;
            tb_q <= tb_d;
            wel_q <= wel_d;
            busy_q <= busy_d;
            sec_q <= sec_d;
            flock_q <= flock_d;
            clock_q <= clock_d;
            lock_q <= lock_d;
            start_q <= start_d;
            rej_q <= rej_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            osec_q <= osec_d;
            bcnt_q <= bcnt_d;
        end
    end

    // Status bits go back to the link as a slowly changing level
    always_ff @(posedge sclk_i) begin
        rd_q <= {clock_q, flock_q, tb_q, lvl_q, wel_q | busy_q};
    end

    assign op_start_o = start_q;
    assign op_kind_o = kind_q;
    assign op_addr_o = addr_q;
    assign op_secure_o = osec_q;
    assign protect_level_o = lvl_q;
    assign bottom_select_o = tb_q;
    assign write_enable_latch_o = wel_q;
    assign busy_o = busy_q;
    assign secure_mode_o = sec_q;
    assign security_reg_o = {clock_q, flock_q};
    assign reject_o = rej_q;
endmodule : sfp_protect

// File: testbench/sfp_protect_checker.sv
// Purpose: Port-level assertions for the protect and framing block
// Assumes: One core clock domain, synchronous active-high reset
// Notes: Attached by bind, sees only top-level ports
`timescale 1ns/1ns
module sfp_protect_checker (
    input wire logic mclk_i,               // Core clock
    input wire logic srst_i,               // Synchronous reset
    input wire logic factory_lock_i,       // Factory lock strap
    input wire logic op_start_o,           // Operation start pulse
    input wire logic op_secure_o,          // Secure area target
    input wire logic write_enable_latch_o, // Write enable latch
    input wire logic busy_o,               // Operation in progress
    input wire logic secure_mode_o,        // Secure area mode
    input wire logic [1:0] security_reg_o, // Lock bits
    input wire logic reject_o              // Reject pulse
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence s_start;
        $rose(op_start_o);
    endsequence
    a_start_then_busy: assert property (s_start |=> busy_o[*4])
        else $error("busy did not follow a start");
    a_start_when_idle: assert property (op_start_o |-> !$past(busy_o))
        else $error("operation started while busy");
    a_start_needs_wel: assert property (op_start_o |-> $past(write_enable_latch_o))
        else $error("operation started without write enable");
    a_start_not_rejected: assert property (op_start_o |-> !reject_o)
        else $error("start and reject together");
    a_reject_one_pulse: assert property (reject_o |=> !reject_o)
        else $error("reject longer than one cycle");
    a_secure_no_array: assert property (op_start_o && $past(secure_mode_o) |-> op_secure_o)
        else $error("main array reached in secure mode");
    a_factory_lock_shown: assert property (factory_lock_i |-> ##[0:4] security_reg_o[0])
        else $error("factory lock not reported");
    a_factory_lock_kept: assert property (security_reg_o[0] |=> security_reg_o[0])
        else $error("factory lock cleared");
    a_customer_lock_kept: assert property (security_reg_o[1] |=> security_reg_o[1])
        else $error("customer lock cleared");
endmodule : sfp_protect_checker
bind sfp_protect sfp_protect_checker i_chk (.mclk_i(mclk_i), .srst_i(srst_i),
    .factory_lock_i(factory_lock_i), .op_start_o(op_start_o), .op_secure_o(op_secure_o),
    .write_enable_latch_o(write_enable_latch_o), .busy_o(busy_o),
    .secure_mode_o(secure_mode_o), .security_reg_o(security_reg_o), .reject_o(reject_o));

// File: testbench/sfp_host.sv
// Purpose: Behavioural host controller driving serial frames
// Assumes: Mode 0, link clock 12 ns, clock still between frames
// Notes: Data line shows the inverse of its last bit once released
`timescale 1ns/1ns
module sfp_host (
    output logic sclk_o, // Serial clock
    output logic cs_n_o, // Chip select, low active
    output logic si_o,        // Serial data to device
    input wire logic so_i,    // Serial data from device
    input wire logic so_oe_i, // Device drives its data line
    output logic [7:0] rx_o,  // Last eight bits seen on the data line
    output logic oe_o         // Drive enable seen during the frame
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        rx_o = 8'h00;
        oe_o = 1'b0;
    end
    // Bit count need not be a byte multiple, so misframed commands can be sent
    task automatic xfer(input logic [39:0] d, input int n);
        cs_n_o = 1'b0;
        oe_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = (i < 40) ? d[39-i] : 1'b0;
            #6 rx_o = {rx_o[6:0], so_i};
            oe_o = oe_o | so_oe_i;
            sclk_o = 1'b1;
            #6 sclk_o = 1'b0;
        end
        #6 cs_n_o = 1'b1;
        si_o = ~si_o;
    endtask : xfer
endmodule : sfp_host

// File: testbench/test_serial_flash_protect_and_framing.sv
// Purpose: Self-checking bench for the protect and framing block
// Assumes: Array engine answers done at random after each start
// Notes: Seed fixed so every run repeats
`timescale 1ns/1ns
module test_serial_flash_protect_and_framing;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic factory_lock_i = 1'b0;
    logic op_done_i = 1'b0;
    logic hold_done = 1'b0;
    logic st, rj;
    wire sclk, cs_n, si, so, so_oe, op_start, op_secure, write_enable_latch, busy, sec_mode, reject, bottom;
    wire [2:0] op_kind;
    wire [24:0] op_addr;
    wire [3:0] level;
    wire [1:0] sec_reg;
    wire [7:0] rx;
    wire oe_seen;
    int errors = 0;
    int comparisons = 0;
    always #25 mclk_i = ~mclk_i;
    always @(negedge mclk_i) op_done_i <= busy && !hold_done && (($urandom % 3) == 0);
    sfp_host h (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe), .rx_o(rx),
        .oe_o(oe_seen));
    sfp_protect i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .so_oe_o(so_oe), .factory_lock_i(factory_lock_i),
        .op_done_i(op_done_i), .op_start_o(op_start), .op_kind_o(op_kind),
        .op_addr_o(op_addr), .op_secure_o(op_secure), .protect_level_o(level),
        .bottom_select_o(bottom), .write_enable_latch_o(write_enable_latch), .busy_o(busy),
        .secure_mode_o(sec_mode), .security_reg_o(sec_reg), .reject_o(reject));
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic logic prot(input int lvl, input logic tb, input int blk);
        int n;
        if (lvl == 0) return 1'b0;
        if (lvl >= 10) return 1'b1;
        n = 1 << (lvl - 1);
        return tb ? (blk < n) : (blk >= 512 - n);
    endfunction : prot
    // Bounded wait for the array engine; a hang ends the run as a failure
    task automatic wait_idle;
        int k;
        for (k = 0; k < 300 && !hold_done && busy !== 1'b0; k++) @(negedge mclk_i);
        if (k == 300) begin
            errors++;
            test_done();
        end
    endtask : wait_idle
    // Start and reject pulses are caught at falling edges, where they are settled
    task automatic frame(input logic [39:0] d, input int n);
        @(negedge mclk_i);
        h.xfer(d, n);
        st = 1'b0;
        rj = 1'b0;
        repeat (8) begin
            @(negedge mclk_i);
            st = st | op_start;
            rj = rj | reject;
        end
        wait_idle();
    endtask : frame
    task automatic cmd(input logic [7:0] c, input logic [31:0] arg, input int n);
        frame({c, arg}, n);
    endtask : cmd
    initial begin
        int blk;
        int sel;
        logic [31:0] r;
        logic [7:0] pc;
        logic [2:0] ek;
        r = $urandom(64193);
        repeat (8) @(posedge mclk_i);
        @(negedge mclk_i) srst_i = 1'b0;
        check("wel_reset", write_enable_latch, 1'b0);
        for (int lvl = 0; lvl < 16; lvl++) for (int tb = 0; tb < 2; tb++) begin
            cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
            cmd(sfp_pkg::CMD_WRITE_STATUS_CMD, {1'b0, tb[0], lvl[3:0], 2'b00, 24'h0}, 16);
            check("level", level, lvl[3:0]);
            check("bottom", bottom, tb[0]);
            cmd(sfp_pkg::CMD_RDSR, 32'h0, 16);
            check("status_read", rx, {2'b00, tb[0], lvl[3:0], 1'b0});
            for (int k = 0; k < 5; k++) begin
                blk = k == 0 ? 0 : k == 1 ? 511 : k == 2 ? 255 : k == 3 ? 256 : $urandom % 512;
                sel = $urandom % 3;
                pc = sel == 0 ? sfp_pkg::CMD_PP : sel == 1 ? sfp_pkg::CMD_SE : sfp_pkg::CMD_BE;
                ek = sel == 0 ? sfp_pkg::OP_PROG : sel == 1 ? sfp_pkg::OP_SERASE :
                    sfp_pkg::OP_BERASE;
                cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
                cmd(pc, {7'h0, blk[8:0], 16'h0}, 40);
                check("prog_start", st, !prot(lvl, tb[0], blk));
                check("prog_kind", op_kind,
                    prot(lvl, tb[0], blk) ? sfp_pkg::OP_NONE : ek);
                check("wel_after", write_enable_latch, 1'b0);
                if (st) check("prog_block", op_addr[24:16], blk[8:0]);
            end
        end
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_WRITE_STATUS_CMD, 32'h0, 16);
        cmd(sfp_pkg::CMD_PP, 32'h0005_0000, 40);
        check("no_wel_start", st, 1'b0);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_PP, 32'h0005_0000, 43);
        check("misframed", {st, rj}, 2'b01);
        cmd(8'hff, 32'h0, 16);
        check("bad_opcode", rj, 1'b1);
        check("so_off", oe_seen, 1'b0);
        cmd(sfp_pkg::CMD_RDSR, 32'h0, 13);
        check("partial_read", rj, 1'b0);
        check("read_drive", oe_seen, 1'b1);
        hold_done = 1'b1;
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_PP, 32'h0003_0000, 40);
        cmd(sfp_pkg::CMD_PP, 32'h0004_0000, 40);
        check("busy_refuse", {st, rj}, 2'b01);
        hold_done = 1'b0;
        wait_idle();
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_WRDI, 32'h0, 8);
        cmd(sfp_pkg::CMD_PP, 32'h0006_0000, 40);
        check("wrdi_blocks", st, 1'b0);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_SBLK, 32'h01ff_3000, 40);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_SE, 32'h01ff_3000, 40);
        check("sector_lock", st, 1'b0);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_PP, 32'h01ff_4000, 40);
        check("sector_free", st, 1'b1);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_SBULK, 32'h01ff_3000, 40);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_SE, 32'h01ff_3000, 40);
        check("sector_unlock", st, 1'b1);
        cmd(sfp_pkg::CMD_ENTER_SECURE_AREA_CMD, 32'h0, 8);
        check("secure_mode", sec_mode, 1'b1);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_PP, 32'h0000_0008, 40);
        check("serial_area", st, 1'b0);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_PP, 32'h0000_0020, 40);
        check("secure_prog", {st, op_secure}, 2'b11);
        cmd(sfp_pkg::CMD_WRITE_ENABLE_CMD, 32'h0, 8);
        cmd(sfp_pkg::CMD_WRITE_SECURITY_REG_CMD, 32'h0, 8);
        check("cust_lock", sec_reg[1], 1'b1);
        cmd(sfp_pkg::CMD_EXIT_SECURE_AREA_CMD, 32'h0, 8);
        check("secure_exit", sec_mode, 1'b0);
        factory_lock_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        check("locks", sec_reg, 2'b11);
        cmd(sfp_pkg::CMD_RDSCUR, 32'h0, 16);
        check("security_read", rx, 8'h03);
        test_done();
    end
endmodule : test_serial_flash_protect_and_framing
